// File: hw/i2csam_params.svh
`ifndef I2CSAM_PARAMS_SVH
`define I2CSAM_PARAMS_SVH

// ----------------------------------------------------------------
// Frame layout on the wire
// ----------------------------------------------------------------
`define I2CSAM_LAST_DATA_CNT 4'h7
`define I2CSAM_ACK_BIT_CNT 4'h8
`define I2CSAM_RW_POS 0
`define I2CSAM_ADDR_MSB 7
`define I2CSAM_ADDR_LSB 1

// ----------------------------------------------------------------
// Reserved addresses, reset values and address register count
// ----------------------------------------------------------------
`define I2CSAM_GC_ADDR 8'h00
`define I2CSAM_BYTE_RST 8'h00
`define I2CSAM_ADDR_REGS 4

`endif

// File: hw/i2csam_pkg.sv
package i2csam_pkg;

    // ------------------------------------------------------------
    // Addressing schemes, in the order of the two-bit select code
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_7B,
        MODE_7B_MASK,
        MODE_10B,
        MODE_10B_MASK
    } i2csam_mode_t;

    // Recognition sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DECIDE,
        ST_WAIT_FALL,
        ST_ACK,
        ST_PASS
    } i2csam_state_t;

    // Software configuration
    typedef struct packed {
        i2csam_mode_t mode;
        logic [3:0][7:0] slave_addr_reg;
        logic addr_buffer_bypass;
        logic general_call_enable;
        logic addr_irq_hold_enable;
    } i2csam_cfg_t;

    // Status seen by software
    typedef struct packed {
        logic bus_free_flag;
        logic addr_match_flag;
        logic read_info;
        logic rx_full;
        logic slave_active;
        logic [7:0] matched_addr_buf0;
        logic [7:0] matched_addr_buf1;
        logic [7:0] receive_buffer_reg;
    } i2csam_status_t;

endpackage

// File: hw/i2csam_top.sv
`timescale 1ns/1ps
`include "i2csam_params.svh"

module i2csam_top #(
    parameter int ADDR_REGS = `I2CSAM_ADDR_REGS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic scl_link,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    input wire i2csam_pkg::i2csam_cfg_t cfg,
    input wire logic flag_clear,
    input wire logic rx_read,
    input wire logic hold_release,
    output i2csam_pkg::i2csam_status_t status
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_REGS != `I2CSAM_ADDR_REGS) begin : g_bad_regs
        $error("i2csam_top supports exactly four address registers");
    end

    // ------------------------------------------------------------
    // Link domain: shift register on the bus clock
    // ------------------------------------------------------------
    logic link_clr;
    logic link_rst_n;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic byte_tgl;
    logic next_byte_tgl;

    // A Start seen by the system side restarts the bit count
    assign link_rst_n = rst_n & ~link_clr;

    // Sample SDA on each rising SCL edge, ninth pulse is acknowledge
    always_comb
    begin
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_byte_tgl = byte_tgl;
        if (bit_cnt == `I2CSAM_ACK_BIT_CNT)
        begin
            next_bit_cnt = 4'h0;
        end
        else
        begin
            next_shift = {shift[6:0], sda_i};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `I2CSAM_LAST_DATA_CNT)
            begin
                next_byte_tgl = ~byte_tgl;
            end
        end
    end

    // Bit count is cleared by the frame without a bus clock edge, and by the ninth rising SCL edge
    always_ff @(posedge scl_link or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_cnt <= 4'h0;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
        end
    end

    // Toggle must never see the frame clear, or a false byte appears
    always_ff @(posedge scl_link or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift <= `I2CSAM_BYTE_RST;
            byte_tgl <= 1'b0;
        end
        else
        begin
            shift <= next_shift;
            byte_tgl <= next_byte_tgl;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers into the system clock
    // ------------------------------------------------------------
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    logic tgl_m;
    logic tgl_s;
    logic tgl_q;
    logic start_evt;
    logic stop_evt;
    logic rise_evt;
    logic fall_evt;
    logic byte_evt;

    // Two stages before use, a third for edge detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            tgl_m <= 1'b0;
            tgl_s <= 1'b0;
            tgl_q <= 1'b0;
        end
        else if (ce)
        begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_q <= sda_s;
            tgl_m <= byte_tgl;
            tgl_s <= tgl_m;
            tgl_q <= tgl_s;
        end
    end

    // SDA moving while SCL stays high marks Start or Stop
    assign start_evt = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_evt = scl_s & scl_q & ~sda_q & sda_s;
    assign rise_evt = scl_s & ~scl_q;
    assign fall_evt = scl_q & ~scl_s;
    assign byte_evt = tgl_s ^ tgl_q;

    // ------------------------------------------------------------
    // Address comparison
    // ------------------------------------------------------------
    logic [7:0] byte_q;
    logic [3:0][7:0] ar;
    logic [3:0] hit7;
    logic mhit0;
    logic mhit2;
    logic hi0;
    logic hi1;
    logic him;
    logic lo0;
    logic lo1;
    logic lom;
    logic gc_byte;

    assign ar = cfg.slave_addr_reg;

    // Direction bit is left out of every high-byte compare
    always_comb
    begin
        for (int i = 0; i < ADDR_REGS; i++)
        begin
            hit7[i] = byte_q[7:1] == ar[i][7:1];
        end
        mhit0 = ((byte_q[7:1] ^ ar[0][7:1]) & ar[1][7:1]) == 7'h00;
        mhit2 = ((byte_q[7:1] ^ ar[2][7:1]) & ar[3][7:1]) == 7'h00;
        hi0 = byte_q[7:1] == ar[1][7:1];
        hi1 = byte_q[7:1] == ar[3][7:1];
        him = ((byte_q[7:1] ^ ar[1][7:1]) & ar[3][7:1]) == 7'h00;
        lo0 = byte_q == ar[0];
        lo1 = byte_q == ar[2];
        lom = ((byte_q ^ ar[0]) & ar[2]) == 8'h00;
        gc_byte = byte_q == `I2CSAM_GC_ADDR;
    end

    // ------------------------------------------------------------
    // Recognition sequence on the system clock
    // ------------------------------------------------------------
    i2csam_pkg::i2csam_state_t st;
    i2csam_pkg::i2csam_state_t next_st;
    logic next_link_clr;
    logic [7:0] next_byte_q;
    logic pend_ack;
    logic next_pend_ack;
    logic pend_gc;
    logic next_pend_gc;
    logic pend_lo;
    logic next_pend_lo;
    logic pend_slot;
    logic next_pend_slot;
    logic seen_rise;
    logic next_seen_rise;
    logic next_scl_oe;
    logic next_sda_oe;
    logic ten_bit;
    logic set_flag;
    logic set_rx;
    i2csam_pkg::i2csam_status_t next_status;

    assign ten_bit = cfg.mode[1];

    // Start wins over everything, Stop ends the frame
    always_comb
    begin
        next_st = st;
        next_link_clr = link_clr;
        next_byte_q = byte_q;
        next_pend_ack = pend_ack;
        next_pend_gc = pend_gc;
        next_pend_lo = pend_lo;
        next_pend_slot = pend_slot;
        next_seen_rise = seen_rise;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_status = status;
        set_flag = 1'b0;
        set_rx = 1'b0;
        next_status.bus_free_flag = scl_s & sda_s;
        if (link_clr && !scl_s)
        begin
            next_link_clr = 1'b0;
        end
        case (st)
            i2csam_pkg::ST_IDLE, i2csam_pkg::ST_PASS:
            begin
                next_st = st;
            end
            i2csam_pkg::ST_ADDR:
            begin
                if (byte_evt)
                begin
                    next_byte_q = shift;
                    next_st = i2csam_pkg::ST_DECIDE;
                end
            end
            i2csam_pkg::ST_DECIDE:
            begin
                next_pend_gc = 1'b0;
                next_st = i2csam_pkg::ST_WAIT_FALL;
                case (cfg.mode)
                    i2csam_pkg::MODE_7B:
                    begin
                        next_pend_ack = |hit7;
                    end
                    i2csam_pkg::MODE_7B_MASK:
                    begin
                        next_pend_ack = mhit0 | mhit2;
                    end
                    i2csam_pkg::MODE_10B:
                    begin
                        if (pend_lo)
                        begin
                            next_pend_ack = pend_slot ? lo1 : lo0;
                        end
                        else
                        begin
                            next_pend_ack = hi0 | hi1;
                            next_pend_slot = ~hi0;
                        end
                    end
                    default:
                    begin
                        next_pend_ack = pend_lo ? lom : him;
                    end
                endcase
                // Zero address is the general call, 7-bit modes only
                if (!ten_bit && gc_byte)
                begin
                    next_pend_gc = 1'b1;
                    next_pend_ack = cfg.general_call_enable;
                end
            end
            i2csam_pkg::ST_WAIT_FALL:
            begin
                if (fall_evt && pend_ack)
                begin
                    // Eighth falling edge: flag, store, acknowledge
                    set_flag = 1'b1;
                    next_sda_oe = 1'b1;
                    next_scl_oe = cfg.addr_irq_hold_enable;
                    next_status.slave_active = 1'b1;
                    next_seen_rise = 1'b0;
                    next_st = i2csam_pkg::ST_ACK;
                    if (!pend_lo)
                    begin
                        next_status.read_info = byte_q[`I2CSAM_RW_POS];
                    end
                    if (pend_gc)
                    begin
                        next_status.matched_addr_buf0 = byte_q;
                    end
                    else if (cfg.addr_buffer_bypass)
                    begin
                        set_rx = 1'b1;
                        next_status.receive_buffer_reg = byte_q;
                    end
                    else if (ten_bit && !pend_lo)
                    begin
                        next_status.matched_addr_buf1 = byte_q;
                    end
                    else
                    begin
                        next_status.matched_addr_buf0 = byte_q;
                    end
                end
                else if (fall_evt)
                begin
                    // No match: stay silent until Start or Stop
                    next_st = i2csam_pkg::ST_PASS;
                end
            end
            i2csam_pkg::ST_ACK:
            begin
                if (hold_release)
                begin
                    next_scl_oe = 1'b0;
                end
                if (rise_evt)
                begin
                    next_seen_rise = 1'b1;
                end
                if (seen_rise && fall_evt)
                begin
                    next_sda_oe = 1'b0;
                    // A 10-bit write still owes the low address byte
                    if (ten_bit && !pend_lo
                        && !byte_q[`I2CSAM_RW_POS])
                    begin
                        next_pend_lo = 1'b1;
                        next_st = i2csam_pkg::ST_ADDR;
                    end
                    else
                    begin
                        next_st = i2csam_pkg::ST_PASS;
                    end
                end
            end
            default:
            begin
                next_st = i2csam_pkg::ST_IDLE;
            end
        endcase
        if (start_evt)
        begin
            // Start or Restart: begin a fresh address phase
            next_st = i2csam_pkg::ST_ADDR;
            next_link_clr = 1'b1;
            next_pend_lo = 1'b0;
            next_pend_gc = 1'b0; // No general call carried into a new frame
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
            next_status.slave_active = 1'b0;
        end
        else if (stop_evt)
        begin
            next_st = i2csam_pkg::ST_IDLE;
            next_pend_gc = 1'b0; // Mode may change while the bus idles
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
            next_status.slave_active = 1'b0;
        end
        // Hardware set beats a software clear in the same cycle
        next_status.addr_match_flag =
            set_flag | (status.addr_match_flag & ~flag_clear);
        next_status.rx_full = set_rx | (status.rx_full & ~rx_read);
    end

    // Register the sequence; all pin drivers come from here
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= i2csam_pkg::ST_IDLE;
            link_clr <= 1'b0;
            byte_q <= `I2CSAM_BYTE_RST;
            pend_ack <= 1'b0;
            pend_gc <= 1'b0;
            pend_lo <= 1'b0;
            pend_slot <= 1'b0;
            seen_rise <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            status <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
            link_clr <= next_link_clr;
            byte_q <= next_byte_q;
            pend_ack <= next_pend_ack;
            pend_gc <= next_pend_gc;
            pend_lo <= next_pend_lo;
            pend_slot <= next_pend_slot;
            seen_rise <= next_seen_rise;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_bus_free_level: assert property ((ce && scl_s && sda_s) |=>
        status.bus_free_flag) else $error("bus free flag not set");

    a_ack_needs_match: assert property ($rose(sda_oe) |->
        $past(pend_ack) && st == i2csam_pkg::ST_ACK)
        else $error("acknowledge without a match");

    a_flag_on_fall: assert property ($rose(status.addr_match_flag) |->
        $past(fall_evt) && $past(st) == i2csam_pkg::ST_WAIT_FALL)
        else $error("match flag not on falling edge");

    a_hold_needs_enable: assert property ($rose(scl_oe) |->
        cfg.addr_irq_hold_enable && status.addr_match_flag)
        else $error("clock stretched without hold enable");

    a_gc_seven_only: assert property (pend_gc |-> !ten_bit)
        else $error("general call seen in 10-bit mode");

    a_gc_disabled_nack: assert property (
        (st == i2csam_pkg::ST_WAIT_FALL && pend_gc
         && !cfg.general_call_enable) |-> !pend_ack)
        else $error("disabled general call acknowledged");

    a_rw_capture: assert property (
        (ce && st == i2csam_pkg::ST_WAIT_FALL && fall_evt && pend_ack
         && !pend_lo && !start_evt && !stop_evt)
        |=> status.read_info == $past(byte_q[0]))
        else $error("direction bit not captured");

    a_stop_to_idle: assert property ((ce && stop_evt && !start_evt)
        |=> st == i2csam_pkg::ST_IDLE) else $error("stop not honoured");

    a_start_to_addr: assert property ((ce && start_evt) |=>
        st == i2csam_pkg::ST_ADDR ##1 (link_clr || !ce))
        else $error("start not honoured");

endmodule // i2csam_top

// File: testbench/i2csam_master.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bus master model: open-drain pulls only, pull-ups sit in the bench
// ----------------------------------------------------------------
module i2csam_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    localparam real HALF = 62.5;
    logic ack;
    event ack_ev;

    // Both lines released: bus idles high through the pull-ups
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Waits out a clock stretch; bounded so a stuck slave cannot hang us
    task wait_hi;
        repeat (2000) if (scl !== 1'b1) #5;
    endtask

    // Start only from a free bus; the bench calls it after Stop or reset
    task start;
        #1.3; // Keep bus edges off the system clock's edges
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b1;
    endtask

    // Restart keeps the bus for the next address
    task restart;
        #HALF;
        scl_low = 1'b0;
        wait_hi;
        #HALF;
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b1;
    endtask

    // Stop releases the bus
    task stop;
        #10;
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b0;
        wait_hi;
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask

    // Eight bits MSB first, then the acknowledge slot sampled mid-high
    task write_byte(input logic [7:0] b);
        int i;
        #1.3; // Bus edges sit 1.3 ns after a system clock edge, never on one
        for (i = 7; i >= 0; i--)
        begin
            #10; // SDA moves only well after SCL fell
            sda_low = ~b[i];
            #(HALF - 10);
            scl_low = 1'b0;
            wait_hi;
            #HALF;
            scl_low = 1'b1;
        end
        #10;
        sda_low = 1'b0;
        #(HALF - 10);
        scl_low = 1'b0;
        wait_hi;
        #(HALF / 2);
        ack = ~sda;
        ->ack_ev;
        #(HALF / 2);
        scl_low = 1'b1;
    endtask
endmodule // i2csam_master

// File: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] val;
        logic ack;
        logic [1:0] w;
        logic rdc;
    } i2csam_exp_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic flag_clear = 1'b0;
    logic rx_read = 1'b0;
    logic hold_release = 1'b0;
    logic [7:0] hold_cnt = 8'h00;
    logic [7:0] stretches = 8'h00;
    logic [7:0] got;
    logic [6:0] a7;
    logic rw;
    logic scl_oe, sda_oe, m_scl_low, m_sda_low;
    logic scl_o, sda_o;
    wire logic scl;
    wire logic sda;
    i2csam_pkg::i2csam_cfg_t cfg = '0;
    i2csam_pkg::i2csam_status_t status;
    i2csam_exp_t exp_q[$];
    i2csam_exp_t e;
    int error_cnt = 0;
    int compares = 0;
    int seed = 18;
    int i;

    always #2.5 clock = ~clock;

    // Wired-AND with pull-ups: any party pulling wins
    assign scl = ~(m_scl_low | (scl_oe & ~scl_o));
    assign sda = ~(m_sda_low | (sda_oe & ~sda_o));

    i2csam_top dut (
        .clock(clock), .rst_n(rst_n), .ce(1'b1), .scl_link(scl),
        .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg),
        .flag_clear(flag_clear),
        .rx_read(rx_read), .hold_release(hold_release), .status(status)
    );

    i2csam_master m (
        .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low)
    );

    // ----------------------------------------------------------------
    // Compare tasks and closing
    // ----------------------------------------------------------------
    task chk_bit(input logic x, input logic g);
        compares++;
        if (g !== x)
        begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask

    task chk_byte(input logic [7:0] x, input logic [7:0] g);
        compares++;
        if (g !== x)
        begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask

    task tally_and_finish;
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Software side: release a stretch after 20 cycles, count stretches
    always @(negedge clock)
    begin
        hold_release <= 1'b0;
        hold_cnt <= scl_oe ? hold_cnt + 8'h01 : 8'h00;
        if (scl_oe && hold_cnt == 8'h14)
        begin
            hold_release <= 1'b1;
            stretches <= stretches + 8'h01;
        end
    end

    // Result watcher: each acknowledge slot retires the oldest note
    always @(m.ack_ev)
    begin
        e = exp_q.pop_front();
        got = e.w == 2'h1 ? status.matched_addr_buf0 :
              e.w == 2'h2 ? status.matched_addr_buf1 :
              status.receive_buffer_reg;
        chk_bit(e.ack, m.ack);
        chk_bit(e.ack, status.addr_match_flag);
        chk_bit(e.ack && e.w == 2'h3, status.rx_full);
        // A NACK slot leaves both lines high, so the bus then reads free
        chk_bit(~e.ack, status.bus_free_flag);
        chk_bit(e.ack | ~e.rdc, status.slave_active);
        if (e.ack && e.rdc)
            chk_bit(e.val[0], status.read_info);
        if (e.ack)
            chk_byte(e.val, got);
    end

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    task set_cfg(input logic [1:0] md, input logic [31:0] r,
                 input logic [2:0] f);
        @(negedge clock);
        cfg.mode = i2csam_pkg::i2csam_mode_t'(md);
        cfg.slave_addr_reg = r;
        {cfg.addr_buffer_bypass, cfg.general_call_enable,
            cfg.addr_irq_hold_enable} = f;
    endtask

    // Clearing flag and buffer first makes every byte's result fresh
    task xfer(input logic [7:0] b, input logic a, input logic [1:0] w,
              input logic rdc);
        exp_q.push_back('{b, a, w, rdc});
        @(negedge clock);
        flag_clear <= 1'b1;
        rx_read <= 1'b1;
        @(negedge clock);
        flag_clear <= 1'b0;
        rx_read <= 1'b0;
        m.write_byte(b);
    endtask

    task stop_idle;
        m.stop;
        repeat (10) @(negedge clock);
        chk_bit(1'b1, status.bus_free_flag);
    endtask

    task a7_frame(input logic [7:0] b, input logic a, input logic [1:0] w);
        m.start;
        xfer(b, a, w, 1'b1);
        stop_idle;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        chk_bit(1'b1, status.bus_free_flag);
        // Plain 7-bit: each register alone, bypass alternating
        a7 = 7'h40 | 7'($random(seed));
        for (i = 0; i < 4; i++)
        begin
            set_cfg(2'h0, {a7 ^ 7'h3, 1'b0, a7 ^ 7'h2, 1'b0,
                a7 ^ 7'h1, 1'b0, a7, 1'b0}, {i[0], 2'b00});
            rw = 1'($random(seed));
            a7_frame({a7 ^ 7'(i), rw}, 1'b1, i[0] ? 2'h3 : 2'h1);
        end
        a7_frame({a7 ^ 7'h4, 1'b0}, 1'b0, 2'h1);
        // Masked 7-bit with stretching
        set_cfg(2'h1, 32'hFE30F0A0, 3'b001);
        a7_frame(8'hAE, 1'b1, 2'h1);
        a7_frame(8'hB0, 1'b0, 2'h1);
        a7_frame(8'h31, 1'b1, 2'h1);
        a7_frame(8'h32, 1'b0, 2'h1);
        chk_byte(8'h02, stretches);
        // 10-bit: prefix compared as stored, low byte tied to its pair
        set_cfg(2'h2, 32'h0266F25A, 3'b000);
        m.start;
        xfer(8'hF2, 1'b1, 2'h2, 1'b1);
        xfer(8'h5A, 1'b1, 2'h1, 1'b0);
        m.restart;
        xfer(8'h02, 1'b1, 2'h2, 1'b1);
        xfer(8'h66, 1'b1, 2'h1, 1'b0);
        m.restart;
        xfer(8'h02, 1'b1, 2'h2, 1'b1);
        xfer(8'h5A, 1'b0, 2'h1, 1'b0);
        stop_idle;
        a7_frame(8'hF3, 1'b1, 2'h2);
        a7_frame(8'hF6, 1'b0, 2'h2);
        // Masked 10-bit through the receive buffer
        set_cfg(2'h3, 32'hFEF0F25A, 3'b100);
        m.start;
        xfer(8'hF2, 1'b1, 2'h3, 1'b1);
        xfer(8'h55, 1'b1, 2'h3, 1'b0);
        m.restart;
        xfer(8'hF2, 1'b1, 2'h3, 1'b1);
        xfer(8'h6A, 1'b0, 2'h3, 1'b0);
        stop_idle;
        // General call: no zero in the address registers
        set_cfg(2'h0, 32'hA6A4A2A0, 3'b111);
        a7_frame(8'h00, 1'b1, 2'h1);
        chk_byte(8'h03, stretches);
        set_cfg(2'h0, 32'hA6A4A2A0, 3'b001);
        a7_frame(8'h00, 1'b0, 2'h1);
        set_cfg(2'h2, 32'hA6A4A2A0, 3'b011);
        a7_frame(8'h00, 1'b0, 2'h1);
        tally_and_finish;
    end

    // Watchdog: the whole sequence needs about a twelfth of this
    initial
    begin
        #400000;
        error_cnt++;
        tally_and_finish;
    end
endmodule // tb_top
